/* File: inc/crf_pkg.sv */
// constants, types and register map of the cpu register file
`default_nettype none
package crf_pkg;
  // ==========================================================
  // register map, byte offsets on the register bus
  localparam logic [7:0] OFS_DATA0   = 8'h00;
  localparam logic [7:0] OFS_DATA1   = 8'h04;
  localparam logic [7:0] OFS_DATA2   = 8'h08;
  localparam logic [7:0] OFS_DATA3   = 8'h0C;
  localparam logic [7:0] OFS_ADDR0   = 8'h10;
  localparam logic [7:0] OFS_ADDR1   = 8'h14;
  localparam logic [7:0] OFS_FBASE   = 8'h18;
  localparam logic [7:0] OFS_SBASE   = 8'h1C;
  localparam logic [7:0] OFS_VTB     = 8'h20;
  localparam logic [7:0] OFS_PC      = 8'h24;
  localparam logic [7:0] OFS_USP     = 8'h28;
  localparam logic [7:0] OFS_ISP     = 8'h2C;
  localparam logic [7:0] OFS_FLAGS   = 8'h30;
  localparam logic [7:0] OFS_PAIR_LO = 8'h34;
  localparam logic [7:0] OFS_PAIR_HI = 8'h38;
  localparam logic [7:0] OFS_APAIR   = 8'h3C;
  localparam logic [7:0] OFS_ACT_SP  = 8'h40;
  // ==========================================================
  // flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_I = 6;
  localparam int FLG_U = 7;
  // ==========================================================
  // values after reset
  localparam logic [15:0] RST_W16   = 16'h0000;
  localparam logic [19:0] RST_W20   = 20'h00000;
  localparam logic [10:0] RST_FLAGS = 11'h000;
  // ==========================================================
  // memory map
  localparam logic [19:0] SFR_HI   = 20'h002FF;
  localparam logic [19:0] RAM_LO   = 20'h00400;
  localparam logic [19:0] DFL_LO   = 20'h02400;
  localparam logic [19:0] DFL_HI   = 20'h02BFF;
  localparam logic [19:0] VEC_LO   = 20'h0FFDC;
  localparam logic [19:0] ROM_HI   = 20'h0FFFF;
  localparam int unsigned ROM_TOP1 = 32'h0001_0000;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
  typedef enum logic [2:0] {
    RGN_SFR  = 3'h0,
    RGN_RAM  = 3'h1,
    RGN_DFL  = 3'h2,
    RGN_ROM  = 3'h3,
    RGN_VEC  = 3'h4,
    RGN_NONE = 3'h5
  } crf_region_e;
  typedef struct packed {
    logic        valid;
    logic        arith;
    logic        wide;
    logic        carry;
    logic        ovf;
    logic [31:0] result;
  } crf_alu_s;
  typedef struct packed {
    logic        valid;
    logic [7:0]  ofs;
    logic [3:0]  be;
    logic [31:0] data;
  } crf_wr_s;
endpackage
`default_nettype wire

/* File: design/crf_regfile.sv */
// cpu register file, flags and memory map decode with axi4-lite access
// Function
// - four 16-bit data registers for transfer and arithmetic.
// - first two data registers split into independently writable bytes.
// - data2:data0 and data3:data1 form 32-bit pairs.
// - two 16-bit address registers for indirect and relative addressing.
// - address1:address0 form one 32-bit address register.
// - 16-bit frame base register for frame-relative addressing.
// - 16-bit static base register for static-relative addressing.
// - 20-bit register holds vector table start address.
// - 20-bit program counter holds next instruction address.
// - user and interrupt stack pointers, stack-select flag picks one.
// - processor state lives in an 11-bit flag register.
// - carry flag takes carry, borrow or shifted-out bit.
// - zero flag set on zero arithmetic result, cleared on nonzero arithmetic result.
// - sign flag set on negative arithmetic result, cleared on non-negative arithmetic result.
// - bank-select flag picks register bank 0 or 1.
// - overflow flag set on overflow, cleared otherwise.
// - decode a 1-Mbyte space from 00000h to FFFFFh.
// - program memory ends at 0FFFFh and grows downward.
// - 0FFDCh to 0FFFFh hold the fixed vector table.
// - data flash sits at 02400h to 02BFFh.
// - internal ram starts at 00400h and grows upward.
`default_nettype none
module crf_regfile #(
  parameter int unsigned ROM_BYTES = 49152,
  parameter int unsigned RAM_BYTES = 2560
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [7:0]          awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [7:0]          araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire crf_pkg::crf_wr_s    core_wr,
  input  wire crf_pkg::crf_alu_s   alu,
  input  wire logic                pc_adv,
  input  wire logic [2:0]          pc_len,
  input  wire logic [19:0]         mem_addr,
  output logic [31:0]              data_pair_low,
  output logic [31:0]              data_pair_high,
  output logic [31:0]              address_pair,
  output logic [15:0]              frame_base,
  output logic [15:0]              static_base,
  output logic [19:0]              vector_table_base,
  output logic [19:0]              program_counter,
  output logic [15:0]              active_sp,
  output logic [10:0]              cpu_flags,
  output logic                     bank_sel,
  output crf_pkg::crf_region_e     region
);
  // ==========================================================
  // memory map limits
  localparam int unsigned ROM_LO_I = crf_pkg::ROM_TOP1 - ROM_BYTES;
  localparam int unsigned RAM_HI_I = 32'h0000_0400 + RAM_BYTES - 1;
  localparam logic [19:0] ROM_LO   = ROM_LO_I[19:0];
  localparam logic [19:0] RAM_HI   = RAM_HI_I[19:0];

  if (ROM_BYTES == 0 || ROM_LO_I <= 32'h0000_2BFF) begin : g_chk_rom
    $error("ROM_BYTES overlaps data flash or is zero");
  end
  if (RAM_BYTES == 0 || RAM_HI_I >= 32'h0000_2400) begin : g_chk_ram
    $error("RAM_BYTES overlaps data flash or is zero");
  end

  // ==========================================================
  // storage
  logic [15:0] data_register_0;
  logic [15:0] data_register_1;
  logic [15:0] data_register_2;
  logic [15:0] data_register_3;
  logic [15:0] address_register_0;
  logic [15:0] address_register_1;
  logic [15:0] user_stack_pointer;
  logic [15:0] interrupt_stack_pointer;
  logic        aw_full;
  logic        w_full;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        axi_do;
  logic        rd_hit;
  logic [31:0] rd_data;
  logic        alu_zero;
  logic        alu_neg;
  crf_pkg::crf_wr_s wsel;

  assign data_pair_low  = {data_register_2, data_register_0};
  assign data_pair_high = {data_register_3, data_register_1};
  assign address_pair   = {address_register_1, address_register_0};
  assign bank_sel       = cpu_flags[crf_pkg::FLG_B];

  // ==========================================================
  // helpers
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= crf_pkg::OFS_ACT_SP);
  endfunction

  function automatic logic wr_on(input logic [7:0] a);
    return wsel.valid && (wsel.ofs == a);
  endfunction

  function automatic logic [15:0] m16(input logic [15:0] o,
                                      input logic [15:0] d,
                                      input logic [1:0]  be);
    return {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
  endfunction

  function automatic logic [19:0] m20(input logic [19:0] o,
                                      input logic [19:0] d,
                                      input logic [2:0]  be);
    return {be[2] ? d[19:16] : o[19:16], m16(o[15:0], d[15:0], be[1:0])};
  endfunction

  // ==========================================================
  // write port: the core wins, the bus write waits
  assign axi_do = aw_full && w_full && !bvalid && !core_wr.valid;

  always_comb begin
    wsel = core_wr;
    if (!core_wr.valid) begin
      wsel.valid = axi_do && mapped(awaddr_q);
      wsel.ofs   = awaddr_q;
      wsel.be    = wstrb_q;
      wsel.data  = wdata_q;
    end
  end

  // ==========================================================
  // axi4-lite write channels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full  <= 1'b0;
      awready  <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (awvalid && awready) begin
      aw_full  <= 1'b1;
      awready  <= 1'b0;
      awaddr_q <= awaddr;
    end else if (bvalid && bready) begin
      aw_full  <= 1'b0;
      awready  <= 1'b1;
    end else if (!aw_full) begin
      awready  <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_full  <= 1'b0;
      wready  <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_full  <= 1'b1;
      wready  <= 1'b0;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (bvalid && bready) begin
      w_full  <= 1'b0;
      wready  <= 1'b1;
    end else if (!w_full) begin
      wready  <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp  <= crf_pkg::RESP_OK;
    end else if (axi_do) begin
      bvalid <= 1'b1;
      bresp  <= mapped(awaddr_q) ? crf_pkg::RESP_OK : crf_pkg::RESP_ERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // axi4-lite read channels
  always_comb begin
    rd_hit  = mapped(araddr);
    rd_data = 32'h0000_0000;
    case (araddr)
      crf_pkg::OFS_DATA0:   rd_data[15:0] = data_register_0;
      crf_pkg::OFS_DATA1:   rd_data[15:0] = data_register_1;
      crf_pkg::OFS_DATA2:   rd_data[15:0] = data_register_2;
      crf_pkg::OFS_DATA3:   rd_data[15:0] = data_register_3;
      crf_pkg::OFS_ADDR0:   rd_data[15:0] = address_register_0;
      crf_pkg::OFS_ADDR1:   rd_data[15:0] = address_register_1;
      crf_pkg::OFS_FBASE:   rd_data[15:0] = frame_base;
      crf_pkg::OFS_SBASE:   rd_data[15:0] = static_base;
      crf_pkg::OFS_VTB:     rd_data[19:0] = vector_table_base;
      crf_pkg::OFS_PC:      rd_data[19:0] = program_counter;
      crf_pkg::OFS_USP:     rd_data[15:0] = user_stack_pointer;
      crf_pkg::OFS_ISP:     rd_data[15:0] = interrupt_stack_pointer;
      crf_pkg::OFS_FLAGS:   rd_data[10:0] = cpu_flags;
      crf_pkg::OFS_PAIR_LO: rd_data = data_pair_low;
      crf_pkg::OFS_PAIR_HI: rd_data = data_pair_high;
      crf_pkg::OFS_APAIR:   rd_data = address_pair;
      crf_pkg::OFS_ACT_SP:  rd_data[15:0] = active_sp;
      default:              rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= crf_pkg::RESP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_data;
      rresp   <= rd_hit ? crf_pkg::RESP_OK : crf_pkg::RESP_ERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ==========================================================
  // data, address and base registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_register_0    <= crf_pkg::RST_W16;
      data_register_1    <= crf_pkg::RST_W16;
      data_register_2    <= crf_pkg::RST_W16;
      data_register_3    <= crf_pkg::RST_W16;
      address_register_0 <= crf_pkg::RST_W16;
      address_register_1 <= crf_pkg::RST_W16;
      frame_base         <= crf_pkg::RST_W16;
      static_base        <= crf_pkg::RST_W16;
      vector_table_base  <= crf_pkg::RST_W20;
    end else begin
      // byte lanes merge, so one half survives a byte write
      if (wr_on(crf_pkg::OFS_DATA0) || wr_on(crf_pkg::OFS_PAIR_LO)) begin
        data_register_0 <= m16(data_register_0, wsel.data[15:0],
                               wsel.be[1:0]);
      end
      if (wr_on(crf_pkg::OFS_DATA1) || wr_on(crf_pkg::OFS_PAIR_HI)) begin
        data_register_1 <= m16(data_register_1, wsel.data[15:0],
                               wsel.be[1:0]);
      end
      if (wr_on(crf_pkg::OFS_DATA2)) begin
        data_register_2 <= m16(data_register_2, wsel.data[15:0],
                               wsel.be[1:0]);
      end else if (wr_on(crf_pkg::OFS_PAIR_LO)) begin
        data_register_2 <= m16(data_register_2, wsel.data[31:16],
                               wsel.be[3:2]);
      end
      if (wr_on(crf_pkg::OFS_DATA3)) begin
        data_register_3 <= m16(data_register_3, wsel.data[15:0],
                               wsel.be[1:0]);
      end else if (wr_on(crf_pkg::OFS_PAIR_HI)) begin
        data_register_3 <= m16(data_register_3, wsel.data[31:16],
                               wsel.be[3:2]);
      end
      if (wr_on(crf_pkg::OFS_ADDR0) || wr_on(crf_pkg::OFS_APAIR)) begin
        address_register_0 <= m16(address_register_0, wsel.data[15:0],
                                  wsel.be[1:0]);
      end
      if (wr_on(crf_pkg::OFS_ADDR1)) begin
        address_register_1 <= m16(address_register_1, wsel.data[15:0],
                                  wsel.be[1:0]);
      end else if (wr_on(crf_pkg::OFS_APAIR)) begin
        address_register_1 <= m16(address_register_1, wsel.data[31:16],
                                  wsel.be[3:2]);
      end
      if (wr_on(crf_pkg::OFS_FBASE)) begin
        frame_base <= m16(frame_base, wsel.data[15:0],
                          wsel.be[1:0]);
      end
      if (wr_on(crf_pkg::OFS_SBASE)) begin
        static_base <= m16(static_base, wsel.data[15:0],
                           wsel.be[1:0]);
      end
      if (wr_on(crf_pkg::OFS_VTB)) begin
        vector_table_base <= m20(vector_table_base, wsel.data[19:0],
                                 wsel.be[2:0]);
      end
    end
  end

  // ==========================================================
  // program counter: a write beats the advance
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      program_counter <= crf_pkg::RST_W20;
    end else if (wr_on(crf_pkg::OFS_PC)) begin
      program_counter <= m20(program_counter, wsel.data[19:0],
                             wsel.be[2:0]);
    end else if (pc_adv) begin
      program_counter <= program_counter + {17'h00000, pc_len};
    end
  end

  // ==========================================================
  // stack pointers; the active alias writes the selected one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      user_stack_pointer      <= crf_pkg::RST_W16;
      interrupt_stack_pointer <= crf_pkg::RST_W16;
    end else begin
      if (wr_on(crf_pkg::OFS_USP) || (wr_on(crf_pkg::OFS_ACT_SP)
          && cpu_flags[crf_pkg::FLG_U])) begin
        user_stack_pointer <= m16(user_stack_pointer, wsel.data[15:0],
                                  wsel.be[1:0]);
      end
      if (wr_on(crf_pkg::OFS_ISP) || (wr_on(crf_pkg::OFS_ACT_SP)
          && !cpu_flags[crf_pkg::FLG_U])) begin
        interrupt_stack_pointer <= m16(interrupt_stack_pointer,
                                       wsel.data[15:0],
                                       wsel.be[1:0]);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_sp <= crf_pkg::RST_W16;
    end else begin
      active_sp <= cpu_flags[crf_pkg::FLG_U] ? user_stack_pointer
                                             : interrupt_stack_pointer;
    end
  end

  // ==========================================================
  // flags: alu results override a same-cycle write
  assign alu_zero = alu.wide ? (alu.result == 32'h0000_0000)
                             : (alu.result[15:0] == 16'h0000);
  assign alu_neg  = alu.wide ? alu.result[31] : alu.result[15];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_flags <= crf_pkg::RST_FLAGS;
    end else begin
      if (wr_on(crf_pkg::OFS_FLAGS)) begin
        cpu_flags <= {wsel.be[1] ? wsel.data[10:8] : cpu_flags[10:8],
                      wsel.be[0] ? wsel.data[7:0]
                                 : cpu_flags[7:0]};
      end
      if (alu.valid) begin
        cpu_flags[crf_pkg::FLG_C] <= alu.carry;
        cpu_flags[crf_pkg::FLG_O] <= alu.ovf;
        if (alu.arith) begin
          cpu_flags[crf_pkg::FLG_Z] <= alu_zero;
          cpu_flags[crf_pkg::FLG_S] <= alu_neg;
        end
      end
    end
  end

  // ==========================================================
  // memory map decode of the full 20-bit space
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      region <= crf_pkg::RGN_NONE;
    end else if (mem_addr <= crf_pkg::SFR_HI) begin
      region <= crf_pkg::RGN_SFR;
    end else if (mem_addr >= crf_pkg::RAM_LO && mem_addr <= RAM_HI) begin
      region <= crf_pkg::RGN_RAM;
    end else if (mem_addr >= crf_pkg::DFL_LO
                 && mem_addr <= crf_pkg::DFL_HI) begin
      region <= crf_pkg::RGN_DFL;
    end else if (mem_addr >= crf_pkg::VEC_LO
                 && mem_addr <= crf_pkg::ROM_HI) begin
      region <= crf_pkg::RGN_VEC;
    end else if (mem_addr >= ROM_LO && mem_addr <= crf_pkg::ROM_HI) begin
      region <= crf_pkg::RGN_ROM;
    end else begin
      region <= crf_pkg::RGN_NONE;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wr_ready;
    aw_full && w_full && !bvalid && !core_wr.valid;
  endsequence
  sequence s_wr_resp;
    bvalid && (bresp == (mapped(awaddr_q) ? 2'h0 : 2'h2));
  endsequence

  a_axi_write_resp: assert property (s_wr_ready |=> s_wr_resp)
    else $error("write response missing or wrong");
  a_zero_flag: assert property (
    alu.valid && alu.arith |=> cpu_flags[2] == $past(alu_zero))
    else $error("zero flag wrong");
  a_sign_flag: assert property (
    alu.valid && alu.arith |=> cpu_flags[3] == $past(alu_neg))
    else $error("sign flag wrong");
  a_carry_ovf: assert property (
    alu.valid |=> cpu_flags[0] == $past(alu.carry)
                  && cpu_flags[5] == $past(alu.ovf))
    else $error("carry or overflow flag wrong");
  a_byte_half_kept: assert property (
    wr_on(8'h00) && wsel.be[1:0] == 2'h1
    |=> data_register_0[15:8] == $past(data_register_0[15:8]))
    else $error("byte write disturbed upper half");
  a_pair_low_write: assert property (
    wr_on(8'h34) && wsel.be == 4'hF
    |=> data_pair_low == $past(wsel.data))
    else $error("data pair write lost");
  a_addr_pair_write: assert property (
    wr_on(8'h3C) && wsel.be == 4'hF
    |=> address_pair == $past(wsel.data))
    else $error("address pair write lost");
  a_pc_advance: assert property (
    pc_adv && !wr_on(8'h24)
    |=> program_counter == $past(program_counter) + 20'($past(pc_len)))
    else $error("program counter did not advance");
  a_active_sp_sel: assert property (
    ##1 active_sp == $past(cpu_flags[7] ? user_stack_pointer
                                        : interrupt_stack_pointer))
    else $error("active stack pointer wrong");
  a_region_dflash: assert property (
    mem_addr >= 20'h02400 && mem_addr <= 20'h02BFF
    |=> region == crf_pkg::RGN_DFL)
    else $error("data flash decode wrong");
  a_region_vector: assert property (
    mem_addr >= 20'h0FFDC |=> region != crf_pkg::RGN_ROM
                              && (region == crf_pkg::RGN_VEC
                                  || $past(mem_addr) > 20'h0FFFF))
    else $error("vector table decode wrong");
  a_region_sfr: assert property (
    mem_addr <= 20'h002FF |=> region == crf_pkg::RGN_SFR)
    else $error("peripheral window decode wrong");
endmodule
`default_nettype wire

/* File: verif/crf_regfile_tb_top.sv */
// self-checking bench for the cpu register file over axi4-lite
`default_nettype none
module crf_regfile_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 clk;
  logic                 rst = 1'b1;
  logic                 awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                 arvalid = 1'b0, rready = 1'b0;
  logic                 awready, wready, bvalid, arready, rvalid, bank_sel;
  logic [7:0]           awaddr = '0, araddr = '0;
  logic [31:0]          wdata = '0, rdata, d, rnd = 32'h0000_0058;
  logic [3:0]           wstrb = '0;
  logic [1:0]           bresp, rresp;
  logic [19:0]          mem_addr = '0;
  logic                 pc_adv = 1'b0;
  logic [2:0]           pc_len = '0;
  crf_pkg::crf_wr_s     core_wr = '0;
  crf_pkg::crf_alu_s    alu = '0;
  crf_pkg::crf_region_e region;
  logic [33:0]          q[$];
  int                   num_errors = 0, check_count = 0;
  logic [36:0] av[4] = '{{5'h1A, 32'h0001_0000}, {5'h19, 32'h0000_8000},
                         {5'h1C, 32'h8000_0000}, {5'h12, 32'h0000_0000}};
  logic [10:0] fv[4] = '{11'h005, 11'h028, 11'h008, 11'h009};
  logic [19:0] ma[13] = '{20'h00000, 20'h002FF, 20'h00300, 20'h00400,
    20'h00DFF, 20'h00E00, 20'h02400, 20'h02BFF, 20'h03FFF, 20'h04000,
    20'h0FFDB, 20'h0FFDC, 20'hFFFFF};
  logic [2:0]  rg[13] = '{3'h0, 3'h0, 3'h5, 3'h1, 3'h1, 3'h5, 3'h2, 3'h2,
    3'h5, 3'h3, 3'h3, 3'h4, 3'h5};

  crf_regfile i_crf_regfile (
    .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .core_wr(core_wr), .alu(alu), .pc_adv(pc_adv), .pc_len(pc_len),
    .mem_addr(mem_addr), .data_pair_low(), .data_pair_high(),
    .address_pair(), .frame_base(), .static_base(),
    .vector_table_base(), .program_counter(), .active_sp(),
    .cpu_flags(), .bank_sel(bank_sel), .region(region));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic end_sim;
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] msk(input logic [7:0] a);
    if (a == crf_pkg::OFS_VTB || a == crf_pkg::OFS_PC)
      return 32'h000F_FFFF;
    if (a == crf_pkg::OFS_FLAGS)
      return 32'h0000_07FF;
    return 32'h0000_FFFF;
  endfunction

  // one bus transfer; the expected answer is noted for the monitor
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] dv, input logic [3:0] s,
                     input logic [33:0] e);
    int n;
    q.push_back(e);
    if (w) begin
      awaddr <= a;
      wdata <= dv;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    n = 0;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) rready <= 1'b0;
      n++;
    end while (n < 40 && (awvalid | wvalid | bready | arvalid | rready));
    if (n >= 40) begin
      num_errors++;
      end_sim();
    end
  endtask

  // ==========================================================
  // response monitor
  always @(posedge clk) begin
    if (bvalid && bready) chk({bresp, 32'h0}, q.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, q.pop_front());
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    bus(0, crf_pkg::OFS_DATA0, '0, '0, 34'h0);
    bus(0, crf_pkg::OFS_FLAGS, '0, '0, 34'h0);
    for (int i = 0; i <= 48; i += 4) begin
      rnd = lfsr(rnd);
      d = (i == 48) ? (rnd & 32'h0000_07FD) : rnd;
      bus(1, 8'(i), d, 4'hF, 34'h0);
      bus(0, 8'(i), '0, '0, {2'h0, d & msk(8'(i))});
    end
    bus(1, crf_pkg::OFS_DATA0, 32'h0000_1234, 4'hF, 34'h0);
    bus(1, crf_pkg::OFS_DATA0, 32'h0000_AB00, 4'h2, 34'h0);
    bus(0, crf_pkg::OFS_DATA0, '0, '0, 34'h0_0000_AB34);
    bus(1, crf_pkg::OFS_DATA2, 32'h0000_5678, 4'hF, 34'h0);
    bus(0, crf_pkg::OFS_PAIR_LO, '0, '0, 34'h0_5678_AB34);
    bus(1, crf_pkg::OFS_DATA0, 32'h0000_00CD, 4'h1, 34'h0);
    bus(0, crf_pkg::OFS_DATA0, '0, '0, 34'h0_0000_ABCD);
    bus(1, crf_pkg::OFS_PC, 32'h0000_1000, 4'hF, 34'h0);
    pc_adv <= 1'b1;
    pc_len <= 3'h5;
    @(posedge clk);
    pc_adv <= 1'b0;
    bus(0, crf_pkg::OFS_PC, '0, '0, 34'h0_0000_1005);
    core_wr <= '{valid: 1'b1, ofs: crf_pkg::OFS_DATA1, be: 4'hF, data: rnd};
    @(posedge clk);
    core_wr <= '0;
    bus(0, crf_pkg::OFS_DATA1, '0, '0, {18'h0, rnd[15:0]});
    bus(1, crf_pkg::OFS_APAIR, 32'hCAFE_F00D, 4'hF, 34'h0);
    bus(0, crf_pkg::OFS_ADDR1, '0, '0, 34'h0_0000_CAFE);
    bus(1, crf_pkg::OFS_USP, 32'h0000_1111, 4'hF, 34'h0);
    bus(1, crf_pkg::OFS_ISP, 32'h0000_2222, 4'hF, 34'h0);
    bus(1, crf_pkg::OFS_FLAGS, 32'h0000_0090, 4'hF, 34'h0);
    chk({33'h0, bank_sel}, 34'h1);
    bus(0, crf_pkg::OFS_ACT_SP, '0, '0, 34'h0_0000_1111);
    bus(1, crf_pkg::OFS_FLAGS, 32'h0000_0000, 4'hF, 34'h0);
    chk({33'h0, bank_sel}, 34'h0);
    bus(0, crf_pkg::OFS_ACT_SP, '0, '0, 34'h0_0000_2222);
    bus(1, 8'h44, 32'hFFFF_FFFF, 4'hF, {crf_pkg::RESP_ERR, 32'h0});
    bus(0, 8'h02, '0, '0, {crf_pkg::RESP_ERR, 32'h0});
    for (int i = 0; i < 4; i++) begin
      alu <= crf_pkg::crf_alu_s'(av[i]);
      @(posedge clk);
      alu <= '0;
      bus(0, crf_pkg::OFS_FLAGS, '0, '0, {23'h0, fv[i]});
    end
    for (int i = 0; i < 13; i++) begin
      mem_addr <= ma[i];
      repeat (2) @(posedge clk);
      chk({31'h0, region}, {31'h0, rg[i]});
      chk({31'h0, region}, {31'h0, rg[i]});
    end
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule
`default_nettype wire
